// >>> common/iomb_pkg.sv
// Shared types and constants for the I/O to memory ordering bridge
package iomb_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int QUEUE_DEPTH = 4;

    typedef enum logic [1:0]
    {
        IOMB_CMD_WR = 2'h1,
        IOMB_CMD_RD = 2'h2
    } iomb_kind_t;

    typedef struct packed
    {
        iomb_kind_t          kind;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } iomb_cmd_t;

    localparam int CMD_W = $bits(iomb_cmd_t);

    typedef enum logic [4:0]
    {
        ST_IDLE  = 5'h01,
        ST_OWN   = 5'h02,
        ST_FLUSH = 5'h04,
        ST_MWR   = 5'h08,
        ST_MRD   = 5'h10
    } iomb_state_t;
endpackage

// >>> hw/iomb_cmd_queue.sv
// In-order command queue holding inbound device memory commands
`timescale 1ns/1ps
module iomb_cmd_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic                          nonempty
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != '0);
    assign nonempty  = out_valid;
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wr_d  = push ? ((wr_q == LAST_IDX) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == LAST_IDX) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Data storage needs no reset; only the pointers and the count define validity
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// >>> hw/iomb_bridge.sv
// System bridge ordering core: inbound device memory traffic versus processor reads
`timescale 1ns/1ps
// Overview of operation
// - Reads toward I/O are retried while posted inbound writes remain buffered
// - Posted device writes and following read return data keep relative order
// - Device write is flushed and owned before later read data reaches processor
// - Memory ownership is taken before the flush command is issued
// - Writes from one device reach memory in issue order
// - Flush, write, flush, write strictly alternate, flushes in order
// - Memory commands are processed in arrival order from the I/O side
// - Write then read from one device stays ordered without software help
// - Interrupt acknowledge read also flushes legacy bridge line buffers
// - Only one outbound I/O command is outstanding at a time
// - Peer write arrives before any processor read triggered by its data
// - Control register operations are done one at a time, in order
module iomb_bridge #(
    parameter int DEPTH = iomb_pkg::QUEUE_DEPTH
) (
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        io_cmd_valid,
    output logic                             io_cmd_ready,
    input  wire iomb_pkg::iomb_cmd_t         io_cmd,
    output logic                             io_rd_rsp_valid,
    output logic [iomb_pkg::DATA_W-1:0]      io_rd_rsp_data,
    output logic                             mem_own_req,
    input  wire logic                        mem_own_gnt,
    output logic                             mem_wr_valid,
    output logic                             mem_rd_valid,
    output logic [iomb_pkg::ADDR_W-1:0]      mem_addr,
    output logic [iomb_pkg::DATA_W-1:0]      mem_wdata,
    input  wire logic                        mem_done,
    input  wire logic [iomb_pkg::DATA_W-1:0] mem_rdata,
    output logic                             cpu_flush_valid,
    output logic [iomb_pkg::ADDR_W-1:0]      cpu_flush_addr,
    input  wire logic                        cpu_flush_ack,
    input  wire logic                        cpu_io_req_valid,
    input  wire logic                        cpu_io_req_intack,
    input  wire logic [iomb_pkg::ADDR_W-1:0] cpu_io_req_addr,
    output logic                             cpu_io_req_ready,
    output logic                             cpu_io_req_retry,
    output logic                             io_out_valid,
    output logic [iomb_pkg::ADDR_W-1:0]      io_out_addr,
    output logic                             io_out_intack,
    output logic                             lb_flush,
    input  wire logic                        io_rtn_valid,
    input  wire logic [iomb_pkg::DATA_W-1:0] io_rtn_data,
    output logic                             cpu_rtn_valid,
    output logic [iomb_pkg::DATA_W-1:0]      cpu_rtn_data,
    input  wire logic                        csr_req_valid,
    output logic                             csr_req_ready,
    output logic                             csr_issue,
    input  wire logic                        csr_done
);
    iomb_pkg::iomb_state_t state_q, state_d;
    iomb_pkg::iomb_cmd_t   cur_q, cur_d, head;
    logic                  head_valid, head_pop, q_nonempty, wr_pending;
    logic                  rsp_v_q, rsp_v_d;
    logic [iomb_pkg::DATA_W-1:0] rsp_q, rsp_d;

    iomb_cmd_queue #(.WIDTH(iomb_pkg::CMD_W), .DEPTH(DEPTH)) u_queue (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (io_cmd_valid),
        .in_ready  (io_cmd_ready),
        .in_data   (io_cmd),
        .out_valid (head_valid),
        .out_ready (head_pop),
        .out_data  (head),
        .nonempty  (q_nonempty)
    );

    // One command at a time, in arrival order; the queue never reorders
    assign head_pop = head_valid && (state_q == iomb_pkg::ST_IDLE);

    // Reads sit in the same queue, so a read after a write sees its data
    assign wr_pending = q_nonempty || (state_q != iomb_pkg::ST_IDLE);

    always_comb
    begin
        state_d = state_q;
        cur_d   = cur_q;
        rsp_v_d = 1'b0;
        rsp_d   = rsp_q;
        case (state_q)
            iomb_pkg::ST_IDLE:
            begin
                if (head_pop)
                begin
                    cur_d   = head;
                    state_d = iomb_pkg::ST_OWN;
                end
            end
            // Ownership first, so any later miss sees the new data
            iomb_pkg::ST_OWN:
                if (mem_own_gnt)
                    state_d = (cur_q.kind == iomb_pkg::IOMB_CMD_WR) ?
                        iomb_pkg::ST_FLUSH : iomb_pkg::ST_MRD;
            iomb_pkg::ST_FLUSH:
                if (cpu_flush_ack)
                    state_d = iomb_pkg::ST_MWR;
            // Ownership is held through the write, making it atomic
            iomb_pkg::ST_MWR:
                if (mem_done)
                    state_d = iomb_pkg::ST_IDLE;
            iomb_pkg::ST_MRD:
                if (mem_done)
                begin
                    rsp_v_d = 1'b1;
                    rsp_d   = mem_rdata;
                    state_d = iomb_pkg::ST_IDLE;
                end
            default:
                state_d = iomb_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_q <= iomb_pkg::ST_IDLE;
            cur_q   <= '0;
            rsp_v_q <= 1'b0;
            rsp_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cur_q   <= cur_d;
            rsp_v_q <= rsp_v_d;
            rsp_q   <= rsp_d;
        end
    end

    assign mem_own_req     = (state_q != iomb_pkg::ST_IDLE);
    assign cpu_flush_valid = (state_q == iomb_pkg::ST_FLUSH);
    assign mem_wr_valid    = (state_q == iomb_pkg::ST_MWR);
    assign mem_rd_valid    = (state_q == iomb_pkg::ST_MRD);
    assign cpu_flush_addr  = cur_q.addr;
    assign mem_addr        = cur_q.addr;
    assign mem_wdata       = cur_q.data;
    assign io_rd_rsp_valid = rsp_v_q;
    assign io_rd_rsp_data  = rsp_q;

    // Outbound processor reads toward I/O
    logic                        out_busy_q, out_busy_d, out_v_q, out_v_d;
    logic                        out_ia_q, out_ia_d, lbf_q, lbf_d;
    logic                        rtn_full_q, rtn_full_d;
    logic [iomb_pkg::ADDR_W-1:0] out_addr_q, out_addr_d;
    logic [iomb_pkg::DATA_W-1:0] rtn_q, rtn_d;
    logic                        io_accept;

    // Retry rather than stall while posted writes drain: no deadlock
    assign cpu_io_req_retry = cpu_io_req_valid && wr_pending;
    assign cpu_io_req_ready = !out_busy_q && !rtn_full_q && !wr_pending;
    assign io_accept        = cpu_io_req_valid && cpu_io_req_ready;

    always_comb
    begin
        out_busy_d = out_busy_q;
        out_v_d    = 1'b0;
        out_ia_d   = out_ia_q;
        out_addr_d = out_addr_q;
        lbf_d      = 1'b0;
        rtn_full_d = rtn_full_q;
        rtn_d      = rtn_q;
        if (io_accept)
        begin
            out_busy_d = 1'b1;
            out_v_d    = 1'b1;
            out_ia_d   = cpu_io_req_intack;
            out_addr_d = cpu_io_req_addr;
            lbf_d      = cpu_io_req_intack;
        end
        if (io_rtn_valid && out_busy_q)
        begin
            out_busy_d = 1'b0;
            rtn_full_d = 1'b1;
            rtn_d      = io_rtn_data;
        end
        if (cpu_rtn_valid)
            rtn_full_d = 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            out_busy_q <= 1'b0;
            out_v_q    <= 1'b0;
            out_ia_q   <= 1'b0;
            out_addr_q <= '0;
            lbf_q      <= 1'b0;
            rtn_full_q <= 1'b0;
            rtn_q      <= '0;
        end
        else
        begin
            out_busy_q <= out_busy_d;
            out_v_q    <= out_v_d;
            out_ia_q   <= out_ia_d;
            out_addr_q <= out_addr_d;
            lbf_q      <= lbf_d;
            rtn_full_q <= rtn_full_d;
            rtn_q      <= rtn_d;
        end
    end

    assign io_out_valid  = out_v_q;
    assign io_out_addr   = out_addr_q;
    assign io_out_intack = out_ia_q;
    assign lb_flush      = lbf_q;
    // Return data waits until every earlier device write is flushed and owned
    assign cpu_rtn_valid = rtn_full_q && !wr_pending;
    assign cpu_rtn_data  = rtn_q;

    // Control register operations, strictly one in flight
    logic csr_busy_q, csr_busy_d, csr_iss_q, csr_iss_d;

    assign csr_req_ready = !csr_busy_q;

    always_comb
    begin
        csr_iss_d  = csr_req_valid && !csr_busy_q;
        csr_busy_d = csr_iss_d ? 1'b1 : (csr_done ? 1'b0 : csr_busy_q);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            csr_busy_q <= 1'b0;
            csr_iss_q  <= 1'b0;
        end
        else
        begin
            csr_busy_q <= csr_busy_d;
            csr_iss_q  <= csr_iss_d;
        end
    end

    assign csr_issue = csr_iss_q;

    // Checks
    logic flushed_q;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            flushed_q <= 1'b0;
        else
            flushed_q <= (state_q == iomb_pkg::ST_FLUSH && cpu_flush_ack) ? 1'b1 :
                         ((state_q == iomb_pkg::ST_IDLE) ? 1'b0 : flushed_q);
    end

    a_retry_pending: assert property (@(posedge core_clk) disable iff (sys_rst)
        cpu_io_req_valid && wr_pending |-> cpu_io_req_retry && !cpu_io_req_ready)
        else $error("read not retried with writes pending");
    a_rtn_behind_wr: assert property (@(posedge core_clk) disable iff (sys_rst)
        cpu_rtn_valid |-> !q_nonempty && state_q == iomb_pkg::ST_IDLE)
        else $error("return data passed an inbound write");
    a_own_before_flush: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(cpu_flush_valid) |-> $past(state_q) == iomb_pkg::ST_OWN && $past(mem_own_gnt))
        else $error("flush issued without ownership");
    a_flush_before_wr: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_wr_valid |-> flushed_q && mem_own_req)
        else $error("memory write before flush");
    a_wr_then_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_wr_valid && mem_done |=> state_q == iomb_pkg::ST_IDLE ##1 !cpu_flush_valid)
        else $error("write and flush not alternating");
    a_inorder_take: assert property (@(posedge core_clk) disable iff (sys_rst)
        head_pop |=> cur_q == $past(head) && state_q == iomb_pkg::ST_OWN)
        else $error("command taken out of order");
    a_one_io_cmd: assert property (@(posedge core_clk) disable iff (sys_rst)
        io_out_valid |=> !io_out_valid && out_busy_q)
        else $error("second outbound command while busy");
    a_intack_flush: assert property (@(posedge core_clk) disable iff (sys_rst)
        io_accept && cpu_io_req_intack |=> lb_flush && io_out_intack)
        else $error("interrupt acknowledge without line buffer flush");
    a_csr_single: assert property (@(posedge core_clk) disable iff (sys_rst)
        csr_issue |-> csr_busy_q ##0 !csr_iss_d)
        else $error("control register operation overlapped");

    c_write_seq: cover property (@(posedge core_clk) disable iff (sys_rst)
        cpu_flush_valid ##[1:20] mem_wr_valid && mem_done);
    c_read_rsp: cover property (@(posedge core_clk) disable iff (sys_rst) io_rd_rsp_valid);
    c_retry: cover property (@(posedge core_clk) disable iff (sys_rst) cpu_io_req_retry);
    c_rtn_held: cover property (@(posedge core_clk) disable iff (sys_rst)
        rtn_full_q && wr_pending ##[1:20] cpu_rtn_valid);
endmodule

// >>> testbench/iomb_far_model.sv
// Far side model: memory, processor cache port, outbound I/O target, register file
`timescale 1ns/1ps
module iomb_far_model (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_own_req,
    output logic             mem_own_gnt,
    input  wire logic        mem_wr_valid,
    input  wire logic        mem_rd_valid,
    input  wire logic [31:0] mem_addr,
    input  wire logic [63:0] mem_wdata,
    output logic             mem_done,
    output logic [63:0]      mem_rdata,
    input  wire logic        cpu_flush_valid,
    output logic             cpu_flush_ack,
    input  wire logic        io_out_valid,
    input  wire logic [31:0] io_out_addr,
    output logic             io_rtn_valid,
    output logic [63:0]      io_rtn_data,
    input  wire logic        csr_issue,
    output logic             csr_done
);
    logic [63:0] mem_q [8];
    logic [3:0]  own_c, fl_c, mc_c, rt_c, cs_c;
    logic        rt_p, cs_p, busy;
    logic [31:0] rt_a;

    assign busy = (mem_wr_valid || mem_rd_valid) && !mem_done;

    // Latency lat stretches every answer, so both prompt and slow partners are seen
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            {own_c, fl_c, mc_c, rt_c, cs_c, rt_p, cs_p, rt_a} <= '0;
            {mem_own_gnt, mem_done, cpu_flush_ack, io_rtn_valid, csr_done} <= '0;
            {mem_rdata, io_rtn_data} <= '0;
            for (int i = 0; i < 8; i++)
                mem_q[i] <= '0;
        end
        else
        begin
            own_c <= mem_own_req ? own_c + 4'h1 : 4'h0;
            mem_own_gnt <= mem_own_req && own_c >= lat;
            fl_c <= (cpu_flush_valid && !cpu_flush_ack) ? fl_c + 4'h1 : 4'h0;
            cpu_flush_ack <= cpu_flush_valid && !cpu_flush_ack && fl_c == lat;
            mc_c <= busy ? mc_c + 4'h1 : 4'h0;
            mem_done <= busy && mc_c == lat;
            // Read data is only valid with the done pulse; otherwise it toggles
            mem_rdata <= ~mem_rdata;
            if (busy && mc_c == lat)
            begin
                mem_rdata <= mem_q[mem_addr[5:3]];
                if (mem_wr_valid)
                    mem_q[mem_addr[5:3]] <= mem_wdata;
            end
            // The I/O target answers each outbound read once its counter reaches lat
            io_rtn_valid <= 1'b0;
            io_rtn_data <= ~io_rtn_data;
            if (io_out_valid)
                {rt_p, rt_c, rt_a} <= {1'b1, 4'h0, io_out_addr};
            else if (rt_p && rt_c == lat)
            begin
                rt_p <= 1'b0;
                io_rtn_valid <= 1'b1;
                io_rtn_data <= {rt_a, ~rt_a};
            end
            else
                rt_c <= rt_c + 4'h1;
            csr_done <= 1'b0;
            if (csr_issue)
                {cs_p, cs_c} <= {1'b1, 4'h0};
            else if (cs_p && cs_c == lat)
                {cs_p, csr_done} <= 2'h1 << 0;
            else
                cs_c <= cs_c + 4'h1;
        end
    end
endmodule

// >>> testbench/io_memory_ordering_bridge_bench.sv
// Self-checking bench for the I/O to memory ordering bridge
`timescale 1ns/1ps
module io_memory_ordering_bridge_bench;
    logic core_clk, sys_rst, io_cmd_valid, io_cmd_ready, io_rd_rsp_valid, mem_own_req;
    logic mem_own_gnt, mem_wr_valid, mem_rd_valid, mem_done, cpu_flush_valid, cpu_flush_ack;
    logic cpu_io_req_valid, cpu_io_req_intack, cpu_io_req_ready, cpu_io_req_retry;
    logic io_out_valid, io_out_intack, lb_flush, io_rtn_valid, cpu_rtn_valid;
    logic csr_req_valid, csr_req_ready, csr_issue, csr_done;
    logic [iomb_pkg::ADDR_W-1:0] mem_addr, cpu_flush_addr, cpu_io_req_addr, io_out_addr;
    logic [iomb_pkg::DATA_W-1:0] io_rd_rsp_data, mem_wdata, mem_rdata, io_rtn_data, cpu_rtn_data;
    logic [3:0]                  lat;
    iomb_pkg::iomb_cmd_t         io_cmd;
    logic [33:0]                 ev_q[$];
    int                          fails, total_checks, own_bad, issue_n;

    iomb_bridge dut_u (.*);
    iomb_far_model far_u (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (!sys_rst)
        begin
            if (cpu_flush_valid && cpu_flush_ack)
            begin
                ev_q.push_back({2'h1, cpu_flush_addr});
                if (mem_own_req !== 1'b1)
                    own_bad++;
            end
            if (mem_wr_valid && mem_done)
                ev_q.push_back({2'h2, mem_addr});
            if (csr_issue)
                issue_n++;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic give_up;
        fails++;
        $display("Error at %0t: wait ran out", $time);
        wrap_up();
    endtask

    // Leaves io_cmd_valid high so back-to-back commands need no extra edge
    task automatic send_cmd(input iomb_pkg::iomb_kind_t k, input logic [31:0] a,
                            input logic [63:0] d);
        int n;
        io_cmd_valid = 1'b1;
        io_cmd = '{kind: k, addr: a, data: d};
        for (n = 0; n < 100 && io_cmd_ready !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 100)
            give_up();
        @(negedge core_clk);
    endtask

    task automatic rd_rsp(input logic [63:0] exp);
        int n;
        for (n = 0; n < 100 && io_rd_rsp_valid !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 100)
            give_up();
        check(io_rd_rsp_data, exp);
        @(negedge core_clk);
    endtask

    // Processor read toward I/O; rt is the retry expected on the first attempt
    task automatic cpu_read(input logic [31:0] a, input logic ik, input logic rt);
        int n;
        {cpu_io_req_valid, cpu_io_req_intack, cpu_io_req_addr} = {1'b1, ik, a};
        #1;
        check({cpu_io_req_retry, cpu_io_req_ready}, {rt, !rt});
        for (n = 0; n < 100 && cpu_io_req_ready !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 100)
            give_up();
        @(negedge core_clk);
        cpu_io_req_valid = 1'b0;
        check({io_out_valid, io_out_intack, lb_flush, io_out_addr}, {1'b1, ik, ik, a});
    endtask

    // ev is the count of logged flush and write events expected before the return
    task automatic cpu_ret(input logic [31:0] a, input int ev);
        int n;
        for (n = 0; n < 100 && cpu_rtn_valid !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 100)
            give_up();
        check(ev_q.size(), ev);
        check(cpu_rtn_data, {a, ~a});
        @(negedge core_clk);
    endtask

    task automatic s_reset;
        check({io_cmd_ready, cpu_io_req_ready, csr_req_ready, io_rd_rsp_valid,
               mem_own_req, cpu_flush_valid, mem_wr_valid, mem_rd_valid, io_out_valid,
               cpu_rtn_valid, csr_issue, lb_flush}, 12'hE00);
    endtask

    // Three writes and two reads fill the queue; same address overwritten in order
    task automatic s_order;
        logic [33:0] exp_q [6];
        lat = 4'h1;
        ev_q.delete();
        send_cmd(iomb_pkg::IOMB_CMD_WR, 32'h8, 64'hA1);
        send_cmd(iomb_pkg::IOMB_CMD_WR, 32'h10, 64'hB2);
        send_cmd(iomb_pkg::IOMB_CMD_WR, 32'h8, 64'hC3);
        send_cmd(iomb_pkg::IOMB_CMD_RD, 32'h8, 64'h0);
        send_cmd(iomb_pkg::IOMB_CMD_RD, 32'h10, 64'h0);
        io_cmd_valid = 1'b0;
        // Four commands wait behind the first write, so a further one is refused
        check(io_cmd_ready, 1'b0);
        rd_rsp(64'hC3);
        rd_rsp(64'hB2);
        exp_q = '{{2'h1, 32'h8}, {2'h2, 32'h8}, {2'h1, 32'h10}, {2'h2, 32'h10},
                  {2'h1, 32'h8}, {2'h2, 32'h8}};
        check(ev_q.size(), 6);
        for (int i = 0; i < 6 && i < ev_q.size(); i++)
            check(ev_q[i], exp_q[i]);
    endtask

    // Processor read while a posted write is pending is retried until it is done
    task automatic s_retry;
        lat = 4'h4;
        ev_q.delete();
        send_cmd(iomb_pkg::IOMB_CMD_WR, 32'h20, 64'h5A5A);
        io_cmd_valid = 1'b0;
        cpu_read(32'h40, 1'b0, 1'b1);
        check(ev_q.size(), 2);
        cpu_ret(32'h40, 2);
    endtask

    // Read return held behind a device write that arrives before it
    task automatic s_hold;
        lat = 4'h3;
        ev_q.delete();
        cpu_read(32'h48, 1'b1, 1'b0);
        check(cpu_io_req_ready, 1'b0);
        send_cmd(iomb_pkg::IOMB_CMD_WR, 32'h28, 64'h77);
        io_cmd_valid = 1'b0;
        cpu_ret(32'h48, 2);
        send_cmd(iomb_pkg::IOMB_CMD_RD, 32'h28, 64'h0);
        io_cmd_valid = 1'b0;
        rd_rsp(64'h77);
    endtask

    // A second register request waits until the first has completed
    task automatic s_csr;
        int n;
        lat = 4'h2;
        issue_n = 0;
        csr_req_valid = 1'b1;
        @(negedge core_clk);
        check({csr_issue, csr_req_ready}, 2'h2);
        for (n = 0; n < 100 && csr_req_ready !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 100)
            give_up();
        check(issue_n, 1);
        @(negedge core_clk);
        csr_req_valid = 1'b0;
        check(csr_issue, 1'b1);
        repeat (8) @(negedge core_clk);
        check({issue_n, csr_req_ready}, {32'h2, 1'b1});
    endtask

    initial
    begin
        {sys_rst, lat, io_cmd, cpu_io_req_addr} = {1'b1, 4'h0, 98'h0, 32'h0};
        {io_cmd_valid, cpu_io_req_valid, cpu_io_req_intack, csr_req_valid} = 4'h0;
        {fails, total_checks, own_bad, issue_n} = '0;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        s_reset();
        s_order();
        s_retry();
        s_hold();
        s_csr();
        check(own_bad, 0);
        wrap_up();
    end
endmodule
